// [program_vector_table_lookup.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Program sequencer with vectors and table read
// ----------------------------------------
module program_vector_table_lookup
    import pvt_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,              // Any system reset cause
    input wire logic i_step,              // Instruction slot completes
    input wire seq_cmd_t i_cmd,           // Operation for this slot
    input wire logic i_irq,               // Interrupt service request
    input wire table_idx_t i_idx,         // High and low index registers
    input wire logic [WORD_W-1:0] i_rom_data, // Program ROM word
    output logic [PC_W-1:0] o_rom_addr,   // Program ROM address
    output logic [PC_W-1:0] o_pc,         // Program counter
    output logic [7:0] o_accumulator,     // Table low byte
    output logic [7:0] o_lookup_high,     // Table high byte
    output logic o_acc_we,                // Accumulator write strobe
    output logic o_irq_ack,               // Interrupt entry pulse
    output logic o_reserved_fetch,        // Instruction fetch fell in reserved area; table fetches are not flagged
    output logic [3:0] o_stack_level      // Occupied stack levels
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    seq_state_t state;                    // Sequencer state
    seq_state_t next_state;
    logic [PC_W-1:0] pc;                  // Program counter
    logic [PC_W-1:0] next_pc;
    logic [7:0] acc;                      // Accumulator copy
    logic [7:0] next_acc;
    logic [7:0] lookup_high;              // Lookup high byte
    logic [7:0] next_lookup_high;
    logic acc_we;                         // Write strobe
    logic next_acc_we;
    logic irq_ack;                        // Entry pulse
    logic next_irq_ack;
    logic push;                           // Stack push
    logic pop;                            // Stack pop
    logic [PC_W-1:0] push_data;           // Address pushed
    logic [PC_W-1:0] stack_top;           // Address popped
    logic [PC_W-1:0] table_addr;          // Table read address
    logic [15:0] table_full;              // Index pair, untruncated

    // ----------------------------------------
    // Table address from index registers
    // ----------------------------------------
    assign table_full = {i_idx.high_index, i_idx.low_index};
    assign table_addr = table_full[PC_W-1:0];

    // ----------------------------------------
    // Sequencer next-state logic
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_pc = pc;
        next_acc = acc;
        next_lookup_high = lookup_high;
        next_acc_we = 1'b0;
        next_irq_ack = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        push_data = pc;
        unique case (state)
            ST_RUN: begin
                if (i_step && i_irq) begin
                    // Push then vector; no accumulator or flag save
                    push = 1'b1;
                    push_data = pc;
                    next_pc = IRQ_VECTOR;
                    next_irq_ack = 1'b1;
                    next_state = ST_IRQ;
                end else if (i_step) begin
                    unique case (i_cmd.op)
                        OP_JUMP: next_pc = i_cmd.target;
                        OP_CALL: begin
                            push = 1'b1;
                            push_data = pc + 1'b1;
                            next_pc = i_cmd.target;
                        end
                        OP_RET, OP_RETURN_FROM_INTERRUPT: begin
                            pop = 1'b1;
                            next_pc = stack_top;
                        end
                        OP_ADD_PCL: begin
                            // Low byte wraps, high bits untouched
                            next_pc = {pc[PC_W-1:8], pc[7:0] + i_cmd.addend};
                        end
                        OP_TABLE: next_state = ST_TABLE;
                        default: next_pc = pc + 1'b1;
                    endcase
                end
            end
            ST_TABLE: begin
                // Capture word; index registers left as they are
                next_acc = i_rom_data[7:0];
                next_lookup_high = i_rom_data[15:8];
                next_acc_we = 1'b1;
                next_pc = pc + 1'b1;
                next_state = ST_RUN;
            end
            ST_IRQ: next_state = ST_RUN;
            default: next_state = ST_RUN;
        endcase
    end

    // Register sequencer state; every cause resets all
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state <= ST_RUN;
            pc <= RESET_VECTOR;
            acc <= REG_RESET;
            lookup_high <= REG_RESET;
            acc_we <= 1'b0;
            irq_ack <= 1'b0;
        end else begin
            state <= next_state;
            pc <= next_pc;
            acc <= next_acc;
            lookup_high <= next_lookup_high;
            acc_we <= next_acc_we;
            irq_ack <= next_irq_ack;
        end
    end

    // ----------------------------------------
    // Stack instance
    // ----------------------------------------
    return_stack #(
        .DEPTH(STACK_DEPTH),
        .W(PC_W)
    ) u_stack (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_push(push),
        .i_pop(pop),
        .i_data(push_data),
        .o_top(stack_top),
        .o_level(o_stack_level)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_rom_addr = (state == ST_TABLE) ? table_addr : pc;
    assign o_pc = pc;
    assign o_accumulator = acc;
    assign o_lookup_high = lookup_high;
    assign o_acc_we = acc_we;
    assign o_irq_ack = irq_ack;
    // Flag user fetches landing in reserved words
    assign o_reserved_fetch = (state != ST_TABLE) &&
        ((pc >= RSV_LO_FIRST && pc <= RSV_LO_LAST) || pc >= RSV_HI_FIRST);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_reset_pc;
        @(posedge i_clk) !i_nrst |=> (o_pc == RESET_VECTOR && o_accumulator == REG_RESET);
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("pc not zero after reset");

    property p_irq_vector;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && i_irq) |=> (o_pc == IRQ_VECTOR && o_irq_ack);
    endproperty
    a_irq_vector: assert property (p_irq_vector) else $error("interrupt did not vector");

    property p_irq_push;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && i_irq && o_stack_level < 4'h8)
            |=> (stack_top == $past(pc) && o_stack_level == $past(o_stack_level) + 4'h1);
    endproperty
    a_irq_push: assert property (p_irq_push) else $error("pc not pushed on interrupt");

    property p_irq_no_save;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && i_irq) |=> $stable(o_accumulator) && !o_acc_we;
    endproperty
    a_irq_no_save: assert property (p_irq_no_save) else $error("accumulator touched on interrupt");

    property p_table_addr;
        @(posedge i_clk) disable iff (!i_nrst) state == ST_TABLE |-> o_rom_addr == {i_idx.high_index[2:0], i_idx.low_index};
    endproperty
    a_table_addr: assert property (p_table_addr) else $error("table address wrong");

    property p_table_data;
        @(posedge i_clk) disable iff (!i_nrst) state == ST_TABLE
            |=> (o_accumulator == $past(i_rom_data[7:0]) && o_lookup_high == $past(i_rom_data[15:8]) && o_acc_we);
    endproperty
    a_table_data: assert property (p_table_data) else $error("table data misplaced");

    property p_add_no_carry;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && !i_irq && i_cmd.op == OP_ADD_PCL)
            |=> o_pc[PC_W-1:8] == $past(pc[PC_W-1:8]);
    endproperty
    a_add_no_carry: assert property (p_add_no_carry) else $error("carry reached high byte");

    property p_return_from_interrupt_pop;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && !i_irq && i_cmd.op == OP_RETURN_FROM_INTERRUPT)
            |=> o_pc == $past(stack_top);
    endproperty
    a_return_from_interrupt_pop: assert property (p_return_from_interrupt_pop) else $error("return address wrong");

    property p_stack_bound;
        @(posedge i_clk) disable iff (!i_nrst) o_stack_level <= 4'h8;
    endproperty
    a_stack_bound: assert property (p_stack_bound) else $error("stack level above eight");

    // ----------------------------------------
    // Reset, table, interrupt, stack, low-byte add and reserved-area checks
    // ----------------------------------------
    // Every reset cause clears all sequencer state
    property p_reset_all;
        @(posedge i_clk) !i_nrst |=> (o_lookup_high == REG_RESET && !o_acc_we && !o_irq_ack
            && o_stack_level == 4'h0 && state == ST_RUN);
    endproperty
    a_reset_all: assert property (p_reset_all) else $error("state not cleared by reset");

    // First fetch after reset comes from the reset vector
    property p_reset_fetch;
        @(posedge i_clk) !i_nrst |=> o_rom_addr == RESET_VECTOR;
    endproperty
    a_reset_fetch: assert property (p_reset_fetch) else $error("first fetch not at reset vector");

    // Upper address bits come from the high index
    property p_table_high;
        @(posedge i_clk) disable iff (!i_nrst) state == ST_TABLE
            |-> o_rom_addr[PC_W-1:8] == i_idx.high_index[PC_W-9:0];
    endproperty
    a_table_high: assert property (p_table_high) else $error("table high address wrong");

    // Low address byte comes from the low index
    property p_table_low;
        @(posedge i_clk) disable iff (!i_nrst) state == ST_TABLE |-> o_rom_addr[7:0] == i_idx.low_index;
    endproperty
    a_table_low: assert property (p_table_low) else $error("table low address wrong");

    // Table request waits one slot with the counter held
    property p_table_enter;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && !i_irq && i_cmd.op == OP_TABLE)
            |=> (state == ST_TABLE && $stable(o_pc));
    endproperty
    a_table_enter: assert property (p_table_enter) else $error("table read not started");

    // One word fetch, then back to normal running
    property p_table_one_word;
        @(posedge i_clk) disable iff (!i_nrst) state == ST_TABLE
            |=> (state == ST_RUN && o_pc == $past(pc) + 11'h001);
    endproperty
    a_table_one_word: assert property (p_table_one_word) else $error("table read did not finish");

    // Write strobe lasts a single cycle
    property p_acc_we_pulse;
        @(posedge i_clk) disable iff (!i_nrst) o_acc_we |=> !o_acc_we;
    endproperty
    a_acc_we_pulse: assert property (p_acc_we_pulse) else $error("write strobe too long");

    // Bytes change only when a table word lands
    property p_acc_hold;
        @(posedge i_clk) disable iff (!i_nrst) state != ST_TABLE
            |=> ($stable(o_accumulator) && $stable(o_lookup_high));
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("table bytes changed outside a read");

    // Entry pulse lasts a single cycle
    property p_irq_ack_pulse;
        @(posedge i_clk) disable iff (!i_nrst) o_irq_ack |=> !o_irq_ack;
    endproperty
    a_irq_ack_pulse: assert property (p_irq_ack_pulse) else $error("entry pulse too long");

    // Interrupt entry passes through its own state
    property p_irq_enter;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && i_irq) |=> state == ST_IRQ;
    endproperty
    a_irq_enter: assert property (p_irq_enter) else $error("interrupt entry state missed");

    // Slot after entry is refused, vector fetch held
    property p_irq_hold;
        @(posedge i_clk) disable iff (!i_nrst) state == ST_IRQ |=> (state == ST_RUN && $stable(o_pc));
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("vector fetch not held");

    // Call pushes the return address and jumps
    property p_call_push;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && !i_irq && i_cmd.op == OP_CALL)
            |=> (stack_top == $past(pc) + 11'h001 && o_pc == $past(i_cmd.target));
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push or jump wrong");

    // Push at full depth keeps the level at eight
    property p_stack_full;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && !i_irq && i_cmd.op == OP_CALL
            && o_stack_level == 4'h8) |=> o_stack_level == 4'h8;
    endproperty
    a_stack_full: assert property (p_stack_full) else $error("stack level left full depth");

    // Low byte add wraps within eight bits
    property p_add_low;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && !i_irq && i_cmd.op == OP_ADD_PCL)
            |=> o_pc[7:0] == $past(pc[7:0]) + $past(i_cmd.addend);
    endproperty
    a_add_low: assert property (p_add_low) else $error("low byte sum wrong");

    // Plain return pops the same way
    property p_ret_pop;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && i_step && !i_irq && i_cmd.op == OP_RET)
            |=> o_pc == $past(stack_top);
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("plain return address wrong");

    // Top reserved words raise the flag while running
    property p_reserved_top;
        @(posedge i_clk) disable iff (!i_nrst) (state == ST_RUN && o_pc >= RSV_HI_FIRST) |-> o_reserved_fetch;
    endproperty
    a_reserved_top: assert property (p_reserved_top) else $error("reserved top not flagged");

endmodule : program_vector_table_lookup

// [pvt_pkg.sv]
// What this block does
// - Reset vector is one word at zero
// - Any reset cause loads counter with zero
// - Resets return all system registers to defaults
// - Interrupt vector is one word at eight
// - Interrupt pushes counter, then jumps to eight
// - Interrupt entry saves neither accumulator nor flags
// - Table address high byte from high index; only high_index[2:0] is used
// - Table address low byte from low index
// - Word low byte to accumulator, high to lookup
// - High index never carries from low wrap
// - Program words sixteen bits, 2K deep
// - Stack buffer holds eight return addresses
// - Adding into counter low byte never carries
package pvt_pkg;

    // ----------------------------------------
    // Memory geometry and vectors
    // ----------------------------------------
    localparam int PC_W = 11;                           // 2K words
    localparam int WORD_W = 16;                         // Program word width
    localparam int STACK_DEPTH = 8;                     // Return address levels
    localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000; // Reset entry
    localparam logic [PC_W-1:0] IRQ_VECTOR = 11'h008;   // Interrupt entry
    localparam logic [PC_W-1:0] RSV_LO_FIRST = 11'h004; // Reserved low block start
    localparam logic [PC_W-1:0] RSV_LO_LAST = 11'h007;  // Reserved low block end
    localparam logic [PC_W-1:0] RSV_HI_FIRST = 11'h7fe; // Reserved top words
    localparam logic [7:0] REG_RESET = 8'h00;           // Default of system registers

    // ----------------------------------------
    // Operations and carriers
    // ----------------------------------------
    typedef enum logic [2:0] {
        OP_NEXT = 3'h0,       // Sequential fetch
        OP_JUMP = 3'h1,       // Absolute jump
        OP_CALL = 3'h2,       // Call with push
        OP_RET = 3'h3,        // Return with pop
        OP_RETURN_FROM_INTERRUPT = 3'h4,       // Return from interrupt
        OP_ADD_PCL = 3'h5,    // Add accumulator into low byte
        OP_TABLE = 3'h6       // Table read
    } seq_op_t;

    typedef struct packed {
        seq_op_t op;                 // Requested operation
        logic [PC_W-1:0] target;     // Jump or call target
        logic [7:0] addend;          // Accumulator for low-byte add
    } seq_cmd_t;

    typedef struct packed {
        logic [7:0] high_index;      // High index register
        logic [7:0] low_index;       // Low index register
    } table_idx_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,              // Normal fetch
        ST_TABLE = 2'b01,            // Table word pending
        ST_IRQ = 2'b11               // Entering interrupt
    } seq_state_t;

endpackage : pvt_pkg

// [return_stack.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Return address stack
// ----------------------------------------
module return_stack
    import pvt_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int W = PC_W
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [W-1:0] i_data,
    output logic [W-1:0] o_top,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int LW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];               // Return addresses
    logic [LW-1:0] ptr;                      // Next free slot, wraps
    logic [LW:0] level;                      // Occupied levels
    logic [LW-1:0] next_ptr;
    logic [LW:0] next_level;

    // Pointer and level bookkeeping
    always_comb begin
        next_ptr = ptr;
        next_level = level;
        if (i_push) begin
            next_ptr = ptr + 1'b1;
            // Count up until full, then hold at full depth
            if (level < (LW+1)'(DEPTH)) begin
                next_level = level + 1'b1;
            end
        end else if (i_pop) begin
            next_ptr = ptr - 1'b1;
            if (level != '0) begin
                next_level = level - 1'b1;
            end
        end
    end

    // Register pointer and level
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ptr <= '0;
            level <= '0;
        end else begin
            ptr <= next_ptr;
            level <= next_level;
        end
    end

    // Storage; oldest entry is overwritten past eight levels
    always_ff @(posedge i_clk) begin
        if (i_push) begin
            mem[ptr] <= i_data;
        end
    end

    assign o_top = mem[ptr - 1'b1];
    assign o_level = level;
endmodule : return_stack

// [program_rom_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Program ROM model, combinational read
// ----------------------------------------
module program_rom_model
    import pvt_pkg::*;
(
    input wire logic [PC_W-1:0] i_addr, // Word address
    output logic [WORD_W-1:0] o_data    // Word read out
);
    // Both bytes derive from the address, so every word differs from its neighbours
    always_comb begin
        o_data = {i_addr[7:0] ^ 8'hc3, i_addr[10:3] ^ 8'h3c};
    end
endmodule : program_rom_model

// [test_program_vector_table_lookup.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module test_program_vector_table_lookup
    import pvt_pkg::*;
;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic i_clk = 1'b0;              // Core clock
    logic i_nrst = 1'b0;             // Reset, held from time zero
    logic i_step = 1'b0;             // Slot completes
    logic i_irq = 1'b0;              // Interrupt request
    seq_cmd_t i_cmd = '0;            // Operation
    table_idx_t i_idx = '0;          // Index pair
    logic [WORD_W-1:0] rom_data;     // ROM word
    logic [PC_W-1:0] rom_addr;       // ROM address
    logic [PC_W-1:0] pc;             // Program counter
    logic [7:0] acc;                 // Table low byte
    logic [7:0] lookup_high;         // Table high byte
    logic acc_we;                    // Write strobe
    logic irq_ack;                   // Entry pulse
    logic rsv;                       // Reserved fetch flag
    logic [3:0] level;               // Stack occupancy
    int n_fail = 0;                  // Mismatches
    int n_compared = 0;              // Comparisons

    // Clock at 200 MHz
    always #2.5 i_clk = ~i_clk;

    program_vector_table_lookup uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_step(i_step), .i_cmd(i_cmd),
        .i_irq(i_irq), .i_idx(i_idx), .i_rom_data(rom_data), .o_rom_addr(rom_addr), .o_pc(pc),
        .o_accumulator(acc), .o_lookup_high(lookup_high), .o_acc_we(acc_we), .o_irq_ack(irq_ack),
        .o_reserved_fetch(rsv), .o_stack_level(level));
    program_rom_model rom (.i_addr(rom_addr), .o_data(rom_data));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // One instruction slot; returns just after the taking edge has landed
    task automatic step(input seq_op_t op, input logic [PC_W-1:0] tgt, input logic [7:0] add, input logic irq);
        @(posedge i_clk);
        i_step <= 1'b1;
        i_cmd <= '{op, tgt, add};
        i_irq <= irq;
        @(posedge i_clk);
        i_step <= 1'b0;
        i_irq <= 1'b0;
        #1;
    endtask : step

    // Reset for n edges, then check every default
    task automatic do_reset(input int n);
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (n) @(posedge i_clk);
        i_nrst <= 1'b1;
        #1;
        `CHK("pc", 11'h000, pc)
        `CHK("acc", 8'h00, acc)
        `CHK("lookup_high", 8'h00, lookup_high)
        `CHK("level", 4'h0, level)
        `CHK("pulses", 2'b00, {acc_we, irq_ack})
    endtask : do_reset

    // Table read with an index pair, then check address and landed bytes
    task automatic t_table(input logic [7:0] hi, input logic [7:0] lo);
        logic [PC_W-1:0] a;
        logic [PC_W-1:0] p;
        a = {hi[2:0], lo};
        p = pc;
        @(posedge i_clk);
        i_idx <= '{hi, lo};
        step(OP_TABLE, 11'h000, 8'h00, 1'b0);
        `CHK("rom_addr", a, rom_addr)
        @(posedge i_clk);
        #1;
        `CHK("acc", a[10:3] ^ 8'h3c, acc)
        `CHK("lookup_high", a[7:0] ^ 8'hc3, lookup_high)
        `CHK("acc_we", 1'b1, acc_we)
        `CHK("pc", p + 11'h001, pc)
    endtask : t_table

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Interrupt entry, vector, push, untouched accumulator, return
    task automatic t_irq;
        logic [7:0] a0;
        step(OP_JUMP, 11'h123, 8'h00, 1'b0);
        a0 = acc;
        step(OP_NEXT, 11'h000, 8'h00, 1'b1);
        `CHK("pc", IRQ_VECTOR, pc)
        `CHK("irq_ack", 1'b1, irq_ack)
        `CHK("level", 4'h1, level)
        `CHK("acc", a0, acc)
        @(posedge i_clk);
        #1;
        `CHK("irq_ack", 1'b0, irq_ack)
        step(OP_RETURN_FROM_INTERRUPT, 11'h000, 8'h00, 1'b0);
        `CHK("pc", 11'h123, pc)
        `CHK("level", 4'h0, level)
    endtask : t_irq

    // Low-byte add keeps the high part, with and without overflow
    task automatic t_add;
        step(OP_JUMP, 11'h1fd, 8'h00, 1'b0);
        step(OP_ADD_PCL, 11'h000, 8'h05, 1'b0);
        `CHK("pc", 11'h102, pc)
        step(OP_ADD_PCL, 11'h000, 8'h03, 1'b0);
        `CHK("pc", 11'h105, pc)
        // Plain fetch does carry across the byte boundary
        step(OP_JUMP, 11'h1ff, 8'h00, 1'b0);
        step(OP_NEXT, 11'h000, 8'h00, 1'b0);
        `CHK("pc", 11'h200, pc)
    endtask : t_add

    // Nine calls saturate at eight levels, one return drops a level
    task automatic t_stack;
        for (int i = 0; i < 9; i++) begin
            step(OP_CALL, 11'h200 + 11'(i), 8'h00, 1'b0);
            `CHK("level", 4'((i < 8) ? i + 1 : 8), level)
        end
        step(OP_RET, 11'h000, 8'h00, 1'b0);
        `CHK("level", 4'h7, level)
        step(OP_RET, 11'h000, 8'h00, 1'b0);
        `CHK("pc", 11'h207, pc)
        `CHK("level", 4'h6, level)
    endtask : t_stack

    // Reserved area flag at both edges of each reserved block
    task automatic t_rsv;
        logic [PC_W-1:0] adr [6] = '{11'h004, 11'h007, 11'h7fe, 11'h7ff, 11'h008, 11'h003};
        for (int i = 0; i < 6; i++) begin
            step(OP_JUMP, adr[i], 8'h00, 1'b0);
            `CHK("reserved", (i < 4) ? 1'b1 : 1'b0, rsv)
        end
    endtask : t_rsv

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence, ending with a second reset in mid-run
    initial begin
        do_reset(5);
        t_table(8'h01, 8'h23);
        t_irq;
        t_table(8'h02, 8'hff);
        t_table(8'h02, 8'h00);
        t_table(8'h07, 8'hff);
        t_add;
        t_stack;
        t_rsv;
        step(OP_JUMP, 11'h345, 8'h00, 1'b0);
        do_reset(1);
        tally_and_finish;
    end

    // Watchdog well beyond the fewer than a hundred cycles the run needs
    initial begin
        repeat (2000) @(posedge i_clk);
        n_fail++;
        tally_and_finish;
    end
endmodule : test_program_vector_table_lookup
